/* ppm_pkg.sv */
// Shared constants for the multiplexed parallel memory port
package ppm_pkg;
    localparam int unsigned BUS_W = 16;
    localparam int unsigned ADDR_W = 24;
    localparam int unsigned HI_LSB = 8;
    localparam int unsigned FIFO_DEPTH = 16;
    localparam logic ALE_POL_RST = 1'b1;
    localparam logic WIDE_RST = 1'b0;
    localparam int unsigned CLK_MHZ = 125;
    localparam int unsigned PHASE_NS = 16;
    localparam int unsigned PHASE_CYC = (PHASE_NS * CLK_MHZ + 999) / 1000;
    localparam logic [3:0] PHASE_CNT = 4'(PHASE_CYC);
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [3:0] CNT_ONE = 4'h1;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam logic [23:0] ADDR_ZERO = 24'h000000;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_HADDR = 3'b001,
        ST_ADDR = 3'b010,
        ST_GAP = 3'b011,
        ST_DATA = 3'b100,
        ST_DONE = 3'b101
    } port_state_e;
endpackage

/* ppm_fifo.sv */
// Request FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module ppm_fifo #(
    parameter int unsigned WIDTH = 41,
    parameter int unsigned DEPTH = 16
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;

    // Handshakes; full and empty come straight from the count
    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_q[rd_q];

    // Pointer and count update
    always_comb begin
        wr_d = push ? AW'(wr_q + 1'b1) : wr_q;
        rd_d = pop ? AW'(rd_q + 1'b1) : rd_q;
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = (AW+1)'(cnt_q + 1'b1);
        end else if (pop && !push) begin
            cnt_d = (AW+1)'(cnt_q - 1'b1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    // Storage carries no reset; only valid entries are read
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end
endmodule
`default_nettype wire

/* ppm_port.sv */
// Multiplexed address/data parallel memory port with request FIFO
// Function
// - Address and data share sixteen lines; latch strobe marks address phase
// - Port supports 8-bit narrow and 16-bit wide data modes
// - Narrow mode strobes latch whenever upper sixteen address bits change
// - Latch strobe asserted every time a new address is placed
// - Latch strobe resets active high; software may select active low
// - Read strobe low for the whole of every read
// - Write strobe low for the whole of every write
// - In flag mode no new transfer starts; all three strobes stay deasserted once any transfer under way has finished
// - Reset drives read/write high, latch low, bus lines undriven
`timescale 1ns/1ps
`default_nettype none
module ppm_port #(
    parameter int unsigned FIFO_DEPTH = ppm_pkg::FIFO_DEPTH
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic cfg_wide,
    input wire logic cfg_ale_low,
    input wire logic cfg_flag_mode,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic [23:0] req_addr,
    input wire logic [15:0] req_wdata,
    output logic rsp_valid,
    output logic [15:0] rsp_rdata,
    output logic [15:0] shared_bus_lines_o,
    output logic shared_bus_lines_oe_n,
    input wire logic [15:0] shared_bus_lines_i,
    output logic rd_n,
    output logic wr_n,
    output logic ale
);
    localparam int unsigned RW = 1 + ppm_pkg::ADDR_W + ppm_pkg::BUS_W;
    logic f_valid, f_pop;
    logic [RW-1:0] f_data;
    logic f_write;
    logic [23:0] f_addr;
    logic [15:0] f_wdata;
    logic [15:0] bus_s1_q, bus_s2_q;

    ppm_fifo #(.WIDTH(RW), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_sys(clk_sys),
        .rst(rst),
        .in_valid(req_valid),
        .in_ready(req_ready),
        .in_data({req_write, req_addr, req_wdata}),
        .out_valid(f_valid),
        .out_ready(f_pop),
        .out_data(f_data)
    );
    assign {f_write, f_addr, f_wdata} = f_data;

    // Pin input synchroniser; only the second stage is read
    always_ff @(posedge clk_sys) begin
        bus_s1_q <= shared_bus_lines_i;
        bus_s2_q <= bus_s1_q;
    end

    ppm_pkg::port_state_e st_q, st_d;
    logic [3:0] cnt_q, cnt_d;
    logic [15:0] hi_q, hi_d;
    logic hi_ok_q, hi_ok_d;
    logic mode_q, mode_d;
    logic [15:0] dout_q, dout_d;
    logic oe_n_q, oe_n_d;
    logic rd_q, rd_d, wr_q, wr_d, ale_q, ale_d;
    logic rsp_q, rsp_d;
    logic [15:0] rdata_q, rdata_d;
    logic [15:0] up_bits;
    logic cnt_last;

    assign up_bits = f_addr[ppm_pkg::ADDR_W-1:ppm_pkg::HI_LSB];
    assign cnt_last = (cnt_q == ppm_pkg::CNT_ONE);
    assign f_pop = (st_q == ppm_pkg::ST_DONE);

    // Sequencer: optional high-address latch, address, gap, data strobe
    always_comb begin
        st_d = st_q;
        cnt_d = (cnt_q != ppm_pkg::CNT_ZERO) ? 4'(cnt_q - 1'b1) : cnt_q;
        hi_d = hi_q;
        hi_ok_d = hi_ok_q;
        mode_d = mode_q;
        dout_d = dout_q;
        oe_n_d = oe_n_q;
        rd_d = 1'b0;
        wr_d = 1'b0;
        ale_d = 1'b0;
        rsp_d = 1'b0;
        rdata_d = rdata_q;
        if (mode_q != cfg_wide) begin
            hi_ok_d = 1'b0; // Width change invalidates held upper bits
            mode_d = cfg_wide;
        end
        unique case (st_q)
            ppm_pkg::ST_IDLE: begin
                oe_n_d = 1'b1;
                if (f_valid && !cfg_flag_mode) begin
                    cnt_d = ppm_pkg::PHASE_CNT;
                    oe_n_d = 1'b0;
                    ale_d = 1'b1;
                    // A width change in this same cycle must also force the high phase
                    if (!cfg_wide && (!hi_ok_q || mode_q != cfg_wide
                        || up_bits != hi_q)) begin
                        st_d = ppm_pkg::ST_HADDR;
                        dout_d = up_bits;
                        hi_d = up_bits;
                        hi_ok_d = 1'b1;
                    end else begin
                        st_d = ppm_pkg::ST_ADDR;
                        dout_d = cfg_wide ? f_addr[15:0] : {ppm_pkg::BYTE_ZERO, f_addr[7:0]};
                    end
                end
            end
            ppm_pkg::ST_HADDR: begin
                ale_d = !cnt_last;
                if (cnt_last) begin
                    st_d = ppm_pkg::ST_ADDR; // Low byte is a new address, strobe stays asserted through it
                    cnt_d = ppm_pkg::PHASE_CNT;
                    ale_d = 1'b1;
                    dout_d = {ppm_pkg::BYTE_ZERO, f_addr[7:0]};
                end
            end
            ppm_pkg::ST_ADDR: begin
                ale_d = !cnt_last;
                if (cnt_last) begin
                    st_d = ppm_pkg::ST_GAP;
                    cnt_d = ppm_pkg::CNT_ONE;
                end
            end
            ppm_pkg::ST_GAP: begin
                st_d = ppm_pkg::ST_DATA;
                cnt_d = ppm_pkg::PHASE_CNT;
                rd_d = !f_write;
                wr_d = f_write;
                oe_n_d = !f_write;
                dout_d = cfg_wide ? f_wdata : {ppm_pkg::BYTE_ZERO, f_wdata[7:0]};
            end
            ppm_pkg::ST_DATA: begin
                rd_d = !f_write && !cnt_last;
                wr_d = f_write && !cnt_last;
                if (cnt_last) begin
                    st_d = ppm_pkg::ST_DONE; // Write data held one cycle past the strobe
                end
            end
            ppm_pkg::ST_DONE: begin
                st_d = ppm_pkg::ST_IDLE;
                oe_n_d = 1'b1;
                // Synchroniser delay: second stage only now holds data from under the strobe
                if (!f_write) begin
                    rsp_d = 1'b1;
                    rdata_d = cfg_wide ? bus_s2_q : {ppm_pkg::BYTE_ZERO, bus_s2_q[7:0]};
                end
            end
            default: begin
                st_d = ppm_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_q <= ppm_pkg::ST_IDLE;
            cnt_q <= ppm_pkg::CNT_ZERO;
            hi_q <= ppm_pkg::WORD_ZERO;
            hi_ok_q <= 1'b0;
            mode_q <= ppm_pkg::WIDE_RST;
            dout_q <= ppm_pkg::WORD_ZERO;
            oe_n_q <= 1'b1;
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            ale_q <= 1'b0;
            rsp_q <= 1'b0;
            rdata_q <= ppm_pkg::WORD_ZERO;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            hi_q <= hi_d;
            hi_ok_q <= hi_ok_d;
            mode_q <= mode_d;
            dout_q <= dout_d;
            oe_n_q <= oe_n_d;
            rd_q <= rd_d;
            wr_q <= wr_d;
            ale_q <= ale_d;
            rsp_q <= rsp_d;
            rdata_q <= rdata_d;
        end
    end

    // Pin drive; latch polarity applied at the pin, reset state keeps it low
    logic ale_pol_q;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ale_pol_q <= !ppm_pkg::ALE_POL_RST;
        end else begin
            ale_pol_q <= cfg_ale_low;
        end
    end
    assign shared_bus_lines_o = dout_q;
    assign shared_bus_lines_oe_n = oe_n_q;
    assign rd_n = !rd_q;
    assign wr_n = !wr_q;
    assign ale = ale_q ^ ale_pol_q;
    assign rsp_valid = rsp_q;
    assign rsp_rdata = rdata_q;

    // Data strobes never overlap each other or the latch strobe
    strobe_excl_a: assert property (@(posedge clk_sys) disable iff (rst)
        !(rd_q && wr_q) && !(ale_q && (rd_q || wr_q)))
        else $error("strobe overlap");
    flag_quiet_a: assert property (@(posedge clk_sys) disable iff (rst)
        cfg_flag_mode && st_q == ppm_pkg::ST_IDLE |=> !ale_q && !rd_q && !wr_q)
        else $error("strobe in flag mode");
    read_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(rd_q) |-> rd_q [*2] ##1 !rd_q ##1 rsp_q)
        else $error("read strobe width");
    write_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(wr_q) |-> wr_q [*2] ##1 !wr_q && !oe_n_q ##0 !wr_q)
        else $error("write strobe width");
    addr_first_a: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(rd_q) || $rose(wr_q) |-> $past(!ale_q) && $past(ale_q, 3))
        else $error("data before address");
    latch_new_a: assert property (@(posedge clk_sys) disable iff (rst)
        st_q == ppm_pkg::ST_IDLE && f_valid && !cfg_flag_mode |=> ale_q && !oe_n_q)
        else $error("no latch on address");
    hi_change_a: assert property (@(posedge clk_sys) disable iff (rst)
        st_q == ppm_pkg::ST_IDLE && f_valid && !cfg_flag_mode && !cfg_wide
        && up_bits != hi_q |=> st_q == ppm_pkg::ST_HADDR && dout_q == $past(up_bits))
        else $error("high bits not latched");
    bus_idle_a: assert property (@(posedge clk_sys) disable iff (rst)
        st_q == ppm_pkg::ST_IDLE |-> oe_n_q && !rd_q && !wr_q)
        else $error("bus driven while idle");
    wide_addr_a: assert property (@(posedge clk_sys) disable iff (rst)
        st_q == ppm_pkg::ST_IDLE && f_valid && !cfg_flag_mode && cfg_wide
        |=> st_q == ppm_pkg::ST_ADDR && dout_q == $past(f_addr[15:0]))
        else $error("wide address wrong");
endmodule
`default_nettype wire

/* ppm_mem_model.sv */
// Behavioural external memory with transparent upper-address latch
`timescale 1ns/1ps
`default_nettype none
module ppm_mem_model (
    input wire logic clk_sys,
    input wire logic cfg_wide,
    input wire logic cfg_ale_low,
    input wire logic [15:0] bus_o,
    input wire logic bus_oe_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic ale,
    output logic [15:0] bus_i
);
    logic [15:0] mem [logic [23:0]];
    logic [15:0] cur_q = 16'h0000;
    logic [15:0] prev_q = 16'h0000;
    logic [15:0] hi_q = 16'h0000;
    logic pol_q = 1'b0;
    logic act_q = 1'b0;
    logic strb_q = 1'b1;
    int npulse = 0;
    logic act;
    logic [23:0] addr;

    // Polarity is tracked one cycle late, as the port applies it
    assign act = ale ^ pol_q;
    // Upper bits from a fresh high phase, else from what the latch holds
    assign addr = cfg_wide ? {8'h00, cur_q} : {(npulse > 1) ? prev_q : hi_q, cur_q[7:0]};

    // Port drive wins, memory drives during a read, else the pull-ups
    always @* begin
        if (!bus_oe_n) bus_i = bus_o;
        else if (!rd_n) bus_i = mem.exists(addr) ? mem[addr] : 16'h0000;
        else bus_i = 16'hffff;
    end

    // Latch capture, address close on strobe fall, write storage
    always @(posedge clk_sys) begin
        pol_q <= cfg_ale_low;
        act_q <= act;
        strb_q <= rd_n & wr_n;
        if (act === 1'b1 && !bus_oe_n && (!act_q || bus_o != cur_q)) begin
            prev_q <= cur_q;
            cur_q <= bus_o;
            npulse <= npulse + 1;
        end
        if (strb_q && !(rd_n & wr_n)) begin
            hi_q <= (npulse > 1) ? prev_q : hi_q;
            npulse <= 0;
        end
        if (!wr_n) mem[addr] = bus_o;
    end
endmodule
`default_nettype wire

/* muxed_parallel_memory_port_tb_top.sv */
// Self-checking bench for the multiplexed parallel memory port
`timescale 1ns/1ps
`default_nettype none
module muxed_parallel_memory_port_tb_top;
    typedef struct packed {
        logic wide;
        logic pol;
        logic wr;
        logic [23:0] addr;
        logic [15:0] data;
    } row_s;
    logic clk_sys, rst, cfg_wide, cfg_ale_low, cfg_flag_mode;
    logic req_valid, req_ready, req_write, rsp_valid, bus_oe_n, rd_n, wr_n, ale;
    logic [23:0] req_addr, ea;
    logic [15:0] req_wdata, rsp_rdata, bus_o, bus_i;
    logic [15:0] exp_mem [logic [23:0]];
    int error_cnt = 0;
    int cmp_count = 0;
    int cycles = 0;
    int flag_bad = 0;
    int n;
    logic flag_watch = 1'b0;
    // Same upper bits twice, upper-byte aliasing in wide mode, both polarities
    row_s rows [10] = '{
        '{1'b0, 1'b0, 1'b1, 24'h123456, 16'h00a5}, '{1'b0, 1'b0, 1'b1, 24'h123457, 16'h003c},
        '{1'b0, 1'b0, 1'b1, 24'h223456, 16'h0077}, '{1'b0, 1'b1, 1'b0, 24'h123456, 16'h0000},
        '{1'b0, 1'b0, 1'b0, 24'h123457, 16'h0000}, '{1'b1, 1'b0, 1'b1, 24'h7700f0, 16'hbeef},
        '{1'b1, 1'b1, 1'b0, 24'h0000f0, 16'h0000}, '{1'b1, 1'b1, 1'b1, 24'h00ffff, 16'h8001},
        '{1'b0, 1'b1, 1'b0, 24'h223456, 16'h0000}, '{1'b1, 1'b0, 1'b0, 24'h00ffff, 16'h0000}};

    ppm_port #(.FIFO_DEPTH(16)) dut (.clk_sys(clk_sys), .rst(rst), .cfg_wide(cfg_wide),
        .cfg_ale_low(cfg_ale_low), .cfg_flag_mode(cfg_flag_mode), .req_valid(req_valid),
        .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
        .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .shared_bus_lines_o(bus_o), .shared_bus_lines_oe_n(bus_oe_n),
        .shared_bus_lines_i(bus_i), .rd_n(rd_n), .wr_n(wr_n), .ale(ale));
    ppm_mem_model mem_i (.clk_sys(clk_sys), .cfg_wide(cfg_wide), .cfg_ale_low(cfg_ale_low),
        .bus_o(bus_o), .bus_oe_n(bus_oe_n), .rd_n(rd_n), .wr_n(wr_n), .ale(ale), .bus_i(bus_i));

    // 125 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // Hang guard and strobe watch while the lines are flags
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (flag_watch && (rd_n !== 1'b1 || wr_n !== 1'b1 || ale !== cfg_ale_low)) flag_bad++;
        if (cycles == 3000) begin
            error_cnt++;
            summarize();
        end
    end

    task automatic summarize();
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [16:0] exp, input logic [16:0] got);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Inputs move 1 ns after the edge so the sampling edge never races them
    task automatic tick(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask

    // Holds the request until an edge with ready high takes it; caller releases
    task automatic send(input logic w, input logic [23:0] a, input logic [15:0] d);
        int t;
        t = 0;
        req_valid = 1'b1;
        req_write = w;
        req_addr = a;
        req_wdata = d;
        while (req_ready !== 1'b1 && t < 200) begin
            tick(1);
            t++;
        end
        tick(1);
    endtask

    initial begin
        {rst, cfg_wide, cfg_ale_low, cfg_flag_mode, req_valid, req_write} = 6'b100000;
        req_addr = 24'h000000;
        req_wdata = 16'h0000;
        tick(3);
        chk("reset_pins", 17'h0000d, {13'h0000, rd_n, wr_n, ale, bus_oe_n});
        tick(3);
        rst = 1'b0;
        tick(1);
        chk("idle_pins", 17'h0000d, {13'h0000, rd_n, wr_n, ale, bus_oe_n});
        // Table of ordinary transfers, each checked at the memory or the response
        foreach (rows[i]) begin
            cfg_wide = rows[i].wide;
            cfg_ale_low = rows[i].pol;
            tick(3);
            chk("ale_idle", {16'h0000, rows[i].pol}, {16'h0000, ale});
            ea = rows[i].wide ? {8'h00, rows[i].addr[15:0]} : rows[i].addr;
            send(rows[i].wr, rows[i].addr, rows[i].data);
            req_valid = 1'b0;
            if (rows[i].wr) begin
                exp_mem[ea] = rows[i].wide ? rows[i].data : {8'h00, rows[i].data[7:0]};
                tick(14);
                chk("mem_word", {1'b0, exp_mem[ea]}, {1'b0, mem_i.mem[ea]});
            end else begin
                n = 0;
                while (rsp_valid !== 1'b1 && n < 40) begin
                    tick(1);
                    n++;
                end
                chk("rsp_rdata", {1'b1, exp_mem[ea]}, {rsp_valid, rsp_rdata});
                tick(4);
            end
        end
        // Flag mode: queue fills to refusal, nothing reaches the pins
        cfg_wide = 1'b1;
        cfg_ale_low = 1'b0;
        cfg_flag_mode = 1'b1;
        tick(3);
        flag_watch = 1'b1;
        for (int i = 0; i < 16; i++) begin
            send(1'b1, 24'h000100 + 24'(i), 16'ha500 + 16'(i));
        end
        chk("req_ready_full", 17'h00000, {16'h0000, req_ready});
        req_valid = 1'b0;
        tick(20);
        flag_watch = 1'b0;
        chk("flag_strobes", 17'h00000, 17'(flag_bad));
        // Release: the full queue drains back to back
        cfg_flag_mode = 1'b0;
        tick(200);
        for (int i = 0; i < 16; i++) begin
            chk("drain_word", {1'b0, 16'ha500 + 16'(i)}, {1'b0, mem_i.mem[24'h000100 + 24'(i)]});
        end
        // Reset in mid-transfer returns the pins and the queue to idle
        send(1'b1, 24'h000200, 16'h1234);
        req_valid = 1'b0;
        tick(3);
        rst = 1'b1;
        tick(2);
        chk("mid_reset_pins", 17'h0000d, {13'h0000, rd_n, wr_n, ale, bus_oe_n});
        rst = 1'b0;
        tick(1);
        chk("mid_reset_ready", 17'h00001, {16'h0000, req_ready});
        summarize();
    end
endmodule
`default_nettype wire
